//--- hw/l21c_params.svh
// Offsets, field positions and reset values for the line-21 control port
`ifndef L21C_PARAMS_SVH
`define L21C_PARAMS_SVH

// Seven-bit slave addresses, direction flag excluded
`define L21C_ADDR_FIRST   7'h14
`define L21C_ADDR_SECOND  7'h15

// Direction flag values in the address byte
`define L21C_DIR_READ     1'b1
`define L21C_DIR_WRITE    1'b0

// Bit count of a byte before its acknowledge slot
`define L21C_BYTE_BITS    4'h8

// Settings word field positions
`define L21C_F_CHAN_LO    0
`define L21C_F_CHAN_HI    3
`define L21C_F_DEC_ON     4
`define L21C_F_ROWS15     5
`define L21C_F_LINES13    6
`define L21C_F_BOX_BG     7
`define L21C_F_EXT_ATTR   8
`define L21C_F_DATA_ON    9
`define L21C_F_PAL        10
`define L21C_F_VLOCK_EXT  11
`define L21C_F_HLOCK_EXT  12
`define L21C_F_VCO_EXT    13
`define L21C_F_MONO       14
`define L21C_F_IRQ_EN     15
`define L21C_F_BOX_LO     16
`define L21C_F_BOX_HI     23

// Settings after reset: first caption channel, 15 rows, 13 lines, box,
// extended attributes on, box timing 27 half-microseconds (13.5 us)
`define L21C_CFG_RESET    24'h1B01E0

`endif

//--- hw/l21c_pkg.sv
// Types shared by the line-21 control port
package l21c_pkg;
   // Two-wire slave sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR,
      ST_WR_ACK,
      ST_RD,
      ST_RD_ACK
   } l21c_state_t;

   // Display channel selection
   typedef enum logic [3:0] {
      CH_CAP1,
      CH_CAP2,
      CH_CAP3,
      CH_CAP4,
      CH_TXT1,
      CH_TXT2,
      CH_TXT3,
      CH_TXT4,
      CH_XDS,
      CH_USER
   } l21c_chan_t;
endpackage

//--- hw/l21c_sync.sv
// Two-stage synchroniser for the six pin inputs
module l21c_sync
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       nrst_in,
   // Asynchronous pins and their synchronised copies
   input  wire logic [5:0] pins_in,
   output logic      [5:0] pins_out
);
   logic [5:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         meta_q   <= 6'h3F;
         pins_out <= 6'h3F;
      end
      else
      begin
         meta_q   <= pins_in;
         pins_out <= meta_q;
      end
   end
endmodule

//--- hw/l21c_port.sv
// Two-wire slave control port of the line-21 decoder
// Contract
// R1 - Mode pin low selects two-wire slave; separate data output stays released.
// R2 - Mode pin and enable pin both low hold the whole part in reset.
// R3 - System may drive enable from a low-active reset or tie it high.
// R4 - Address select low answers 28h/29h, high answers 2Ah/2Bh.
// R5 - Address byte LSB is direction: one read, zero write.
// R6 - Own address after start is acknowledged on the ninth clock.
// R7 - Receiver acknowledges by holding data low on the ninth clock.
// R8 - Transmitter changes data after clock fall, MSB first; receiver samples on rise.
// R9 - Start is data falling with clock high; stop is data rising with clock high.
// R10 - Master starts only on idle bus; data steady while clock high.
// R11 - Master makes clock, starts and stops; device never drives clock.
// R12 - Vertical lock on video turns the shared vsync pin into interrupt output.
// R13 - Interrupt asserts on any programmed event; host write clears it.
// R14 - Reset loads default settings listed for channel, display and interrupt.
// R15 - Channel choice covers captions, text in two fields, extended data, user.
// R16 - Serial port is the only path for settings, data readout, display load.
// R17 - Device is always a slave and never starts a transfer.
// R18 - Mode pin high selects three-wire slave mode instead.
// R19 - Foreign address after start gets no acknowledge; data line stays released.
module l21c_port
(
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             nrst_in,
   // Mode, enable and address select pins
   input  wire logic             serial_mode_select_in,
   input  wire logic             serial_port_enable_in,
   input  wire logic             addr_select_in,
   // Two-wire bus pins
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_out,
   output logic                  separate_serial_output_out,
   output logic                  separate_serial_output_oe_out,
   output logic                  three_wire_mode_out,
   output logic                  part_reset_out,
   // Shared vsync input / interrupt output pin
   input  wire logic             vsync_in_or_irq_in,
   output logic                  vsync_in_or_irq_out,
   output logic                  vsync_in_or_irq_oe_out,
   output logic                  vsync_sync_out,
   // Received bytes toward the command decoder
   output logic [7:0]            rx_data_out,
   output logic                  rx_valid_out,
   output logic                  rx_first_out,
   input  wire logic             wr_ack_in,
   // Bytes to send on reads
   input  wire logic [7:0]       tx_data_in,
   output logic                  tx_taken_out,
   // Settings word written by the command decoder
   input  wire logic             cfg_we_in,
   input  wire logic [23:0]      cfg_wdata_in,
   output logic [23:0]           cfg_out,
   output l21c_pkg::l21c_chan_t  channel_out,
   // Interrupt events, programmed set and clear
   input  wire logic [7:0]       event_in,
   input  wire logic [7:0]       event_mask_in,
   input  wire logic             irq_clear_in,
   output logic                  irq_pending_out
);
   import l21c_pkg::*;

   `include "l21c_params.svh"

   logic [5:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        sms_s;
   logic        sen_s;
   logic        asel_s;
   logic        vsync_s;
   logic        scl_p;
   logic        sda_p;
   logic        part_rst_q;
   logic        rst_n;
   logic        start_det;
   logic        stop_det;
   logic        scl_rise;
   logic        scl_fall;
   l21c_state_t state_q;
   logic [3:0]  cnt_q;
   logic [7:0]  shift_q;
   logic        dir_q;
   logic        ack_q;
   logic        sda_drv_q;
   logic        first_q;
   logic        addr_hit;
   logic [23:0] cfg_q;

   // Own address for the selected slot
   function automatic logic addr_match(input logic [6:0] a, input logic sel);
      addr_match = (a == (sel ? `L21C_ADDR_SECOND : `L21C_ADDR_FIRST));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and bus conditions

   l21c_sync u_sync
   (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .pins_in    ({vsync_in_or_irq_in, addr_select_in, serial_port_enable_in,
                    serial_mode_select_in, sda_in, scl_in}),
      .pins_out   (pins_s)
   );

   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   assign sms_s   = pins_s[2];
   assign sen_s   = pins_s[3];
   assign asel_s  = pins_s[4];
   assign vsync_s = pins_s[5];

   // R2 both pins low
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         part_rst_q <= 1'b0;
      else
         part_rst_q <= !sms_s && !sen_s;
   end

   assign rst_n = nrst_in && !part_rst_q;

   // Previous bus levels for edge finding
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n)
      begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end
      else
      begin
         scl_p <= scl_s;
         sda_p <= sda_s;
      end
   end

   // R9 start and stop while clock high
   assign start_det = scl_s && scl_p && sda_p && !sda_s;
   assign stop_det  = scl_s && scl_p && !sda_p && sda_s;
   assign scl_rise  = scl_s && !scl_p;
   assign scl_fall  = !scl_s && scl_p;
   // R4 address select
   assign addr_hit  = addr_match(shift_q[7:1], asel_s);

   ////////////////////////////////////////////////////////////////////////
   // Slave sequencer

   // R17 slave only; R11 clock is never driven
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n)
      begin
         state_q      <= ST_IDLE;
         cnt_q        <= 4'h0;
         shift_q      <= 8'h00;
         dir_q        <= `L21C_DIR_WRITE;
         ack_q        <= 1'b0;
         sda_drv_q    <= 1'b0;
         first_q      <= 1'b0;
         rx_data_out  <= 8'h00;
         rx_valid_out <= 1'b0;
         rx_first_out <= 1'b0;
         tx_taken_out <= 1'b0;
      end
      else
      begin
         rx_valid_out <= 1'b0;
         tx_taken_out <= 1'b0;
         // R18 three-wire mode keeps this sequencer idle
         if (sms_s || stop_det)
         begin
            state_q   <= ST_IDLE;
            sda_drv_q <= 1'b0;
         end
         else if (start_det)
         begin
            state_q   <= ST_ADDR;
            cnt_q     <= 4'h0;
            sda_drv_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  sda_drv_q <= 1'b0;
               end
               ST_ADDR:
               begin
                  // R8 sample on rising clock
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q   <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == `L21C_BYTE_BITS)
                  begin
                     // R6 acknowledge own address; R19 ignore others
                     if (addr_hit)
                     begin
                        state_q   <= ST_ADDR_ACK;
                        sda_drv_q <= 1'b1;
                        // R5 direction flag in address LSB
                        dir_q     <= shift_q[0];
                     end
                     else
                        state_q <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (dir_q == `L21C_DIR_READ)
                     begin
                        // R8 first bit out after fall, MSB first
                        state_q      <= ST_RD;
                        shift_q      <= tx_data_in;
                        sda_drv_q    <= !tx_data_in[7];
                        tx_taken_out <= 1'b1;
                     end
                     else
                     begin
                        state_q   <= ST_WR;
                        sda_drv_q <= 1'b0;
                        first_q   <= 1'b1;
                     end
                  end
               end
               ST_WR:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q   <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == `L21C_BYTE_BITS)
                  begin
                     // R7 acknowledge received byte when accepted
                     state_q      <= ST_WR_ACK;
                     sda_drv_q    <= wr_ack_in;
                     rx_data_out  <= shift_q;
                     rx_first_out <= first_q;
                     rx_valid_out <= 1'b1;
                     first_q      <= 1'b0;
                  end
               end
               ST_WR_ACK:
               begin
                  if (scl_fall)
                  begin
                     state_q   <= ST_WR;
                     cnt_q     <= 4'h0;
                     sda_drv_q <= 1'b0;
                  end
               end
               ST_RD:
               begin
                  if (scl_rise)
                     cnt_q <= cnt_q + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_q == `L21C_BYTE_BITS)
                     begin
                        state_q   <= ST_RD_ACK;
                        sda_drv_q <= 1'b0;
                     end
                     else
                     begin
                        shift_q   <= {shift_q[6:0], 1'b0};
                        sda_drv_q <= !shift_q[6];
                     end
                  end
               end
               ST_RD_ACK:
               begin
                  // R7 master acknowledge sampled on ninth rise
                  if (scl_rise)
                     ack_q <= !sda_s;
                  else if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (ack_q)
                     begin
                        state_q      <= ST_RD;
                        shift_q      <= tx_data_in;
                        sda_drv_q    <= !tx_data_in[7];
                        tx_taken_out <= 1'b1;
                     end
                     else
                        state_q <= ST_IDLE;
                  end
               end
               default:
               begin
                  state_q   <= ST_IDLE;
                  sda_drv_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data line and released separate output
   assign sda_out                       = 1'b0;
   assign sda_oe_out                    = sda_drv_q;
   // R1 separate output released in two-wire mode
   assign separate_serial_output_out    = 1'b0;
   assign separate_serial_output_oe_out = 1'b0;
   assign three_wire_mode_out           = sms_s;
   assign part_reset_out                = part_rst_q;

   ////////////////////////////////////////////////////////////////////////
   // Settings and interrupt

   // R14 defaults on reset; R16 loaded only via the serial port
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n)
         cfg_q <= `L21C_CFG_RESET;
      else if (cfg_we_in)
         cfg_q <= cfg_wdata_in;
   end

   assign cfg_out = cfg_q;
   // R15 channel selection decode
   assign channel_out = l21c_chan_t'(cfg_q[`L21C_F_CHAN_HI:`L21C_F_CHAN_LO]);

   // R13 sticky events, set wins over clear
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n)
         irq_pending_out <= 1'b0;
      else if (|(event_in & event_mask_in))
         irq_pending_out <= 1'b1;
      else if (irq_clear_in)
         irq_pending_out <= 1'b0;
   end

   // R12 pin is an output while vertical lock is on video
   assign vsync_in_or_irq_oe_out = !cfg_q[`L21C_F_VLOCK_EXT];
   // Interrupt level only reaches the pin while the pin is an output
   assign vsync_in_or_irq_out    = irq_pending_out && cfg_q[`L21C_F_IRQ_EN]
                                   && !cfg_q[`L21C_F_VLOCK_EXT];
   assign vsync_sync_out         = vsync_s;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_sdo_released: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R1
      !separate_serial_output_oe_out && !(sms_s && sda_drv_q && $past(sms_s)))
      else $error("separate output or data line driven wrongly");

   a_part_reset_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R2
      (!sms_s && !sen_s) |=> part_rst_q ##1 (state_q == ST_IDLE && cfg_q == `L21C_CFG_RESET))
      else $error("part not held in reset");

   a_addr_ack_own: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R6
      (state_q == ST_ADDR && scl_fall && cnt_q == `L21C_BYTE_BITS && addr_hit
       && !sms_s && !start_det && !stop_det) |=> (state_q == ST_ADDR_ACK && sda_drv_q))
      else $error("own address not acknowledged");

   a_foreign_nack: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R19
      (state_q == ST_ADDR && scl_fall && cnt_q == `L21C_BYTE_BITS && !addr_hit
       && !sms_s && !start_det && !stop_det) |=> (state_q == ST_IDLE && !sda_drv_q))
      else $error("foreign address acknowledged");

   a_dir_captured: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R5
      (state_q == ST_ADDR_ACK && $past(state_q) == ST_ADDR) |-> dir_q == $past(shift_q[0]))
      else $error("direction flag not captured");

   a_read_msb_first: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R8
      (state_q == ST_ADDR_ACK && dir_q && scl_fall && !sms_s && !start_det && !stop_det)
      |=> (state_q == ST_RD && sda_drv_q == !$past(tx_data_in[7]) && tx_taken_out))
      else $error("read byte not started MSB first");

   a_start_enters: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R9
      (start_det && !sms_s) |=> (state_q == ST_ADDR && cnt_q == 4'h0 && !sda_drv_q))
      else $error("start not recognised");

   a_stop_leaves: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R9
      stop_det |=> (state_q == ST_IDLE && !sda_drv_q))
      else $error("stop not recognised");

   a_irq_sticky: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R13
      (|(event_in & event_mask_in)) |=> irq_pending_out)
      else $error("interrupt event lost");

   a_irq_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n) // R13
      (irq_clear_in && !(|(event_in & event_mask_in))) |=> !irq_pending_out)
      else $error("interrupt not cleared");

   a_irq_pin_dir: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R12
      vsync_in_or_irq_out |-> (vsync_in_or_irq_oe_out && irq_pending_out))
      else $error("interrupt driven while pin is an input");
endmodule

//--- dv/l21c_host.sv
// Two-wire bus master model that drives the line-21 control port
module l21c_host
(
   // Bus lines: clock driven both high and low, data open drain toward a pull-up
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Half of the bus clock period, raised by the bench for a slow master
   int half_ns = 400;

   // Bus idles released, both lines high
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start, stop and clock
   task automatic bus_start();
      sda_low_out = 1'b0;
      #(half_ns / 2);
      scl_out = 1'b1;
      #(half_ns);
      sda_low_out = 1'b1;
      #(half_ns);
      scl_out = 1'b0;
      #(half_ns / 2);
   endtask

   task automatic bus_stop();
      sda_low_out = 1'b1;
      #(half_ns / 2);
      scl_out = 1'b1;
      #(half_ns);
      sda_low_out = 1'b0;
      #(half_ns);
   endtask

   // data set while clock low, held through the high phase
   task automatic put_bit(input logic b);
      sda_low_out = !b;
      #(half_ns / 2);
      scl_out = 1'b1;
      #(half_ns);
      scl_out = 1'b0;
      #(half_ns / 2);
   endtask

   // line released, sampled at the clock rise
   task automatic get_bit(output logic b);
      sda_low_out = 1'b0;
      #(half_ns / 2);
      scl_out = 1'b1;
      b = sda_in;
      #(half_ns);
      scl_out = 1'b0;
      #(half_ns / 2);
   endtask

   // byte out MSB first, then the ninth clock carries the answer
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(a);
      ack = !a;
   endtask

   // byte in MSB first, then our answer on the ninth clock
   task automatic get_byte(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(!ack);
   endtask
endmodule

//--- dv/test_l21c_port.sv
// Self-checking bench for the line-21 two-wire control port
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module test_l21c_port;
   timeunit 1ns;
   timeprecision 1ps;
   import l21c_pkg::*;

   typedef struct {logic sel; logic [7:0] addr; logic ack;} l21c_row_t;

   logic        clk_sys_in, nrst_in, mode_sel, port_en, addr_sel, scl, host_low;
   logic        wr_ack, vsync_pin, cfg_we, irq_clr, ack, got_first;
   logic        sda_o, sda_oe, sep_o, sep_oe, three_wire, part_rst, irq_pin, irq_oe;
   logic        vsync_sync, rx_valid, rx_first, tx_taken, irq_pend;
   logic [23:0] cfg_wdata, cfg;
   logic [7:0]  tx_data, rx_data, event_v, event_mask, d, e, got_rx;
   l21c_chan_t  chan;
   int          fails, comparisons, cycles;
   wire         sda = !(host_low | (sda_oe & !sda_o));

   // Address select, address byte, expected acknowledge
   l21c_row_t rows [7] = '{'{1'b0, 8'h28, 1'b1}, '{1'b0, 8'h29, 1'b1},
      '{1'b0, 8'h2A, 1'b0}, '{1'b1, 8'h2A, 1'b1}, '{1'b1, 8'h2B, 1'b1},
      '{1'b1, 8'h28, 1'b0}, '{1'b0, 8'h50, 1'b0}};

   ////////////////////////////////////////////////////////////////////////////////
   // Design, far-side master and clock
   l21c_port dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .serial_mode_select_in(mode_sel), .serial_port_enable_in(port_en),
      .addr_select_in(addr_sel), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .separate_serial_output_out(sep_o),
      .separate_serial_output_oe_out(sep_oe), .three_wire_mode_out(three_wire),
      .part_reset_out(part_rst), .vsync_in_or_irq_in(vsync_pin),
      .vsync_in_or_irq_out(irq_pin), .vsync_in_or_irq_oe_out(irq_oe),
      .vsync_sync_out(vsync_sync), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
      .rx_first_out(rx_first), .wr_ack_in(wr_ack), .tx_data_in(tx_data),
      .tx_taken_out(tx_taken), .cfg_we_in(cfg_we), .cfg_wdata_in(cfg_wdata),
      .cfg_out(cfg), .channel_out(chan), .event_in(event_v),
      .event_mask_in(event_mask), .irq_clear_in(irq_clr), .irq_pending_out(irq_pend));

   l21c_host host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   // Capture delivered bytes, swap the read byte once taken, bound the run
   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (rx_valid === 1'b1)
      begin
         got_rx = rx_data;
         got_first = rx_first;
      end
      if (tx_taken === 1'b1)
         tx_data <= ~tx_data;
      if (cycles == 12000)
      begin
         fails++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #10;
   endtask

   task automatic summarize();
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {nrst_in, mode_sel, addr_sel, vsync_pin, cfg_we, irq_clr} = '0;
      {port_en, wr_ack} = 2'b11;
      {cfg_wdata, event_v, event_mask} = '0;
      tx_data = 8'h3C;
      tick(2);
      // Reset defaults: channel 0, 15 rows, 13 lines, box, attributes, 27 half-us
      `CHK(cfg, 24'h1B01E0)
      `CHK(chan, CH_CAP1)
      `CHK({irq_oe, irq_pin}, 2'b10)
      `CHK({sep_oe, sep_o, sda_oe}, 3'b000)
      nrst_in = 1'b1;
      tick(4);
      // Address recognition for both select levels and both directions
      foreach (rows[i])
      begin
         tick(1);
         addr_sel = rows[i].sel;
         tick(4);
         e = tx_data;
         host.bus_start();
         host.put_byte(rows[i].addr, ack);
         `CHK(ack, rows[i].ack)
         if (ack && rows[i].addr[0])
         begin
            host.get_byte(1'b0, d);
            `CHK(d, e)
         end
         host.bus_stop();
      end
      // Command and data bytes, the second refused, then a repeated start read
      tick(1);
      addr_sel = 1'b0;
      tick(4);
      host.bus_start();
      host.put_byte(8'h28, ack);
      `CHK(ack, 1'b1)
      host.put_byte(8'hA5, ack);
      `CHK({ack, got_first, got_rx}, {2'b11, 8'hA5})
      tick(1);
      wr_ack = 1'b0;
      host.put_byte(8'h5A, ack);
      `CHK({ack, got_first, got_rx}, {2'b00, 8'h5A})
      e = tx_data;
      host.bus_start();
      host.put_byte(8'h29, ack);
      `CHK(ack, 1'b1)
      host.get_byte(1'b1, d);
      `CHK(d, e)
      host.get_byte(1'b0, d);
      `CHK(d, ~e)
      host.bus_stop();
      // Three-wire mode ignores the two-wire address
      tick(1);
      {wr_ack, mode_sel} = 2'b11;
      tick(4);
      `CHK(three_wire, 1'b1)
      host.bus_start();
      host.put_byte(8'h28, ack);
      `CHK(ack, 1'b0)
      host.bus_stop();
      tick(1);
      mode_sel = 1'b0;
      // Interrupt enabled, channel set to user content
      {cfg_we, cfg_wdata, event_mask} = {1'b1, 24'h1B81E9, 8'h04};
      tick(1);
      cfg_we = 1'b0;
      `CHK({cfg, chan}, {24'h1B81E9, CH_USER})
      event_v = 8'h02;
      tick(1);
      event_v = 8'h00;
      tick(2);
      `CHK(irq_pend, 1'b0)
      event_v = 8'h04;
      tick(1);
      event_v = 8'h00;
      tick(1);
      `CHK({irq_pend, irq_pin, irq_oe}, 3'b111)
      {event_v, irq_clr} = {8'h04, 1'b1};
      tick(1);
      {event_v, irq_clr} = {8'h00, 1'b0};
      tick(1);
      `CHK(irq_pend, 1'b1)
      irq_clr = 1'b1;
      tick(1);
      irq_clr = 1'b0;
      tick(1);
      `CHK({irq_pend, irq_pin}, 2'b00)
      // External vertical lock turns the shared pin back into an input
      {cfg_we, cfg_wdata, vsync_pin} = {1'b1, 24'h1B89E9, 1'b1};
      tick(1);
      cfg_we = 1'b0;
      tick(3);
      `CHK({irq_oe, vsync_sync}, 2'b01)
      // enable pin used as a low-active system reset
      port_en = 1'b0;
      tick(5);
      `CHK({part_rst, cfg}, {1'b1, 24'h1B01E0})
      port_en = 1'b1;
      tick(6);
      `CHK(part_rst, 1'b0)
      tick(4);
      // Slow master after the part reset
      host.half_ns = 1000;
      host.bus_start();
      host.put_byte(8'h28, ack);
      `CHK(ack, 1'b1)
      host.bus_stop();
      summarize();
   end
endmodule
